// ==== rtl/level_sync.sv ====
// two-flop synchroniser for the comparator trip levels
`timescale 1ns/1ps
`default_nettype none
module level_sync
    import power_monitor_pkg::*;
(
    // clock and reset
    input  wire logic         clock,
    input  wire logic         arst_n,
    input  wire logic         ce,
    // levels
    input  wire trip_levels_t async_in,
    output var  trip_levels_t sync_out
);

    trip_levels_t meta;

    // first stage is read only by the second stage
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            meta     <= '0;
            sync_out <= '0;
        end else if (ce) begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end

endmodule : level_sync
`default_nettype wire

// ==== rtl/power_monitor_pkg.sv ====
// constants and carrier types for the supply-voltage monitor register bank
package power_monitor_pkg;

    // ==========================================================
    // register map (indices; byte address is four times the index)
    localparam logic [15:0] REGION_FIRST_INDEX   = 16'h3000;
    localparam logic [15:0] REGION_LAST_INDEX    = 16'h30FF;
    localparam logic [15:0] CONTROL_ONE_INDEX    = 16'h3040;
    localparam logic [15:0] CONTROL_TWO_INDEX    = 16'h3041;
    localparam logic [15:0] EVENT_STATUS_INDEX   = 16'h3042;
    localparam logic [15:0] EVENT_MASK_INDEX     = 16'h3043;
    localparam int          INDEX_LSB            = 2;
    localparam int          INDEX_MSB            = 17;

    // ==========================================================
    // power_monitor_control_one fields
    localparam int WARNING_FLAG_BIT          = 7;
    localparam int WARNING_ACKNOWLEDGE_BIT   = 6;
    localparam int WARNING_IRQ_ENABLE_BIT    = 5;
    localparam int DETECT_RESET_ENABLE_BIT   = 4;
    localparam int DETECT_STOP_ENABLE_BIT    = 3;
    localparam int DETECTOR_ENABLE_BIT       = 2;
    localparam int REF_BUFFER_DRIVE_BIT      = 1;
    localparam int REF_BUFFER_ENABLE_BIT     = 0;

    // ==========================================================
    // power_monitor_control_two fields
    localparam int DETECT_TRIP_SELECT_BIT    = 6;
    localparam int WARNING_TRIP_SELECT_MSB   = 5;
    localparam int WARNING_TRIP_SELECT_LSB   = 4;

    // ==========================================================
    // event status / mask fields
    localparam int WARNING_EVENT_BIT         = 0;
    localparam int DETECT_EVENT_BIT          = 1;
    localparam int EVENT_COUNT               = 2;

    // ==========================================================
    // reset values
    localparam logic [7:0] CONTROL_ONE_RESET  = 8'h1C;
    localparam logic [7:0] CONTROL_TWO_RESET  = 8'h00;
    localparam logic [1:0] EVENT_STATUS_RESET = 2'h0;
    localparam logic [1:0] EVENT_MASK_RESET   = 2'h0;

    // ==========================================================
    // ahb-lite encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic       HRESP_OKAY    = 1'h0;

    // ==========================================================
    // carrier types
    typedef struct packed {
        logic       detect_low;
        logic       warning_low;
    } trip_levels_t;

    typedef struct packed {
        logic       detector_run;
        logic       detect_trip_select;
        logic [1:0] warning_trip_select;
        logic       ref_buffer_enable;
        logic       ref_buffer_high_drive;
    } analog_ctrl_t;

endpackage : power_monitor_pkg

// ==== rtl/power_monitor_regs.sv ====
// supply-voltage monitor control/status register bank behind an ahb-lite slave
// Summary of operation
// - enabled detect event with reset enable forces reset
// - stop-enable keeps detector running in stop mode
// - detector enable gates detect logic and qualifiers
// - detector enable accepts only first write after reset
// - drive select picks buffer low or high drive
// - buffer enable turns reference buffer on
// - detect trip select is write-once, low/high
// - two-bit warning trip select, four ascending levels
// - reserved bits of control two read zero
// - decode high-page region holding these registers
// - reset enable is write-once, needs detector enable
// - acknowledge clears warning flag only if condition gone
// - warning interrupt while flag and enable set
//
// Local design decisions: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module power_monitor_regs
    import power_monitor_pkg::*;
(
    // clock, reset, enable
    input  wire logic         clock,
    input  wire logic         arst_n,
    input  wire logic         ce,
    // ahb-lite slave
    input  wire logic         hsel,
    input  wire logic [31:0]  haddr,
    input  wire logic [1:0]   htrans,
    input  wire logic         hwrite,
    input  wire logic [2:0]   hsize,
    input  wire logic [31:0]  hwdata,
    input  wire logic         hready,
    output logic              hreadyout,
    output logic              hresp,
    output logic [31:0]       hrdata,
    // analog comparator trip levels and stop state
    input  wire trip_levels_t trip_levels,
    input  wire logic         stop_mode,
    // analog controls, reset and interrupt
    output analog_ctrl_t      analog_ctrl,
    output logic              mcu_reset_request,
    output logic              irq
);

    // ==========================================================
    // state
    logic        warning_flag;
    logic        warning_irq_enable;
    logic        detect_reset_enable;
    logic        detect_stop_enable;
    logic        detector_enable;
    logic        ref_buffer_drive_select;
    logic        ref_buffer_enable;
    logic        detect_trip_select;
    logic [1:0]  warning_trip_select;
    logic [1:0]  event_status;
    logic [1:0]  event_mask;
    logic        lock_one;
    logic        lock_two;
    logic        detect_seen;
    logic        wr_pend;
    logic [15:0] wr_index;
    logic        rd_pend;
    logic [15:0] rd_index;
    trip_levels_t trip_sync;

    // ==========================================================
    // comparator synchronisation
    level_sync u_trip_sync (
        .clock    (clock),
        .arst_n   (arst_n),
        .ce       (ce),
        .async_in (trip_levels),
        .sync_out (trip_sync)
    );

    // ==========================================================
    // bus decode
    // hsize is not decoded: only whole-word transfers are supported
    wire        bus_take    = hsel && (htrans == HTRANS_NONSEQ) && hready;
    wire        wr_take     = bus_take && hwrite;
    wire        rd_take     = bus_take && !hwrite;
    wire [15:0] addr_index  = haddr[INDEX_MSB:INDEX_LSB];
    wire        rd_in_region = (rd_index >= REGION_FIRST_INDEX) && (rd_index <= REGION_LAST_INDEX);
    wire        wr_in_region = (wr_index >= REGION_FIRST_INDEX) && (wr_index <= REGION_LAST_INDEX);
    wire        write_one   = wr_pend && wr_in_region && (wr_index == CONTROL_ONE_INDEX);
    wire        write_two   = wr_pend && wr_in_region && (wr_index == CONTROL_TWO_INDEX);
    wire        write_stat  = wr_pend && wr_in_region && (wr_index == EVENT_STATUS_INDEX);
    wire        write_mask  = wr_pend && wr_in_region && (wr_index == EVENT_MASK_INDEX);
    wire [7:0]  wdata       = hwdata[7:0];

    // ==========================================================
    // monitor behaviour
    // detector runs when enabled, and in stop mode only if stop-enable is set
    wire detector_active = detector_enable && (!stop_mode || detect_stop_enable);
    wire detect_event    = detector_active && trip_sync.detect_low;
    wire warning_present = trip_sync.warning_low;
    wire warning_set     = detector_active && warning_present;
    wire ack_write       = write_one && wdata[WARNING_ACKNOWLEDGE_BIT];
    wire ack_clear       = ack_write && !warning_present;
    wire [1:0] event_set = {detect_event && !detect_seen, warning_set && !warning_flag};
    wire [1:0] stat_clear = write_stat ? wdata[1:0] : 2'h0;

    // ==========================================================
    // read data
    wire [7:0] read_one = {warning_flag, 1'b0, warning_irq_enable, detect_reset_enable,
                           detect_stop_enable, detector_enable, ref_buffer_drive_select,
                           ref_buffer_enable};
    // bit 7 and bits 3:0 are reserved and read zero
    wire [7:0] read_two = {1'b0, detect_trip_select, warning_trip_select, 4'h0};
    wire [7:0] read_sel = !rd_in_region                      ? 8'h00 :
                          (rd_index == CONTROL_ONE_INDEX)    ? read_one :
                          (rd_index == CONTROL_TWO_INDEX)    ? read_two :
                          (rd_index == EVENT_STATUS_INDEX)   ? {6'h00, event_status} :
                          (rd_index == EVENT_MASK_INDEX)     ? {6'h00, event_mask} :
                                                               8'h00;

    // ==========================================================
    // next values
    wire        next_reset_request = detect_event && detect_reset_enable;
    wire        next_irq = (warning_flag && warning_irq_enable) || |(event_status & event_mask);
    wire analog_ctrl_t next_analog_ctrl = '{
        detector_run:          detector_active,
        detect_trip_select:    detect_trip_select,
        warning_trip_select:   warning_trip_select,
        ref_buffer_enable:     ref_buffer_enable,
        ref_buffer_high_drive: ref_buffer_enable && ref_buffer_drive_select
    };

    // ==========================================================
    // bus phase tracking
    // reads take one wait state so that a write in the preceding data phase is seen
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            wr_pend   <= 1'b0;
            wr_index  <= 16'h0000;
            rd_pend   <= 1'b0;
            rd_index  <= 16'h0000;
            hreadyout <= 1'b1;
        end else if (ce) begin
            wr_pend   <= wr_take;
            rd_pend   <= rd_take;
            hreadyout <= !rd_take;
            if (wr_take) begin
                wr_index <= addr_index;
            end
            if (rd_take) begin
                rd_index <= addr_index;
            end
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            hrdata <= 32'h0000_0000;
            hresp  <= HRESP_OKAY;
        end else if (ce && rd_pend) begin
            hrdata <= {24'h00_0000, read_sel};
        end
    end

    // ==========================================================
    // control one
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            warning_irq_enable      <= CONTROL_ONE_RESET[WARNING_IRQ_ENABLE_BIT];
            detect_reset_enable     <= CONTROL_ONE_RESET[DETECT_RESET_ENABLE_BIT];
            detect_stop_enable      <= CONTROL_ONE_RESET[DETECT_STOP_ENABLE_BIT];
            detector_enable         <= CONTROL_ONE_RESET[DETECTOR_ENABLE_BIT];
            ref_buffer_drive_select <= CONTROL_ONE_RESET[REF_BUFFER_DRIVE_BIT];
            ref_buffer_enable       <= CONTROL_ONE_RESET[REF_BUFFER_ENABLE_BIT];
            lock_one                <= 1'b0;
        end else if (ce && write_one) begin
            warning_irq_enable      <= wdata[WARNING_IRQ_ENABLE_BIT];
            detect_stop_enable      <= wdata[DETECT_STOP_ENABLE_BIT];
            ref_buffer_drive_select <= wdata[REF_BUFFER_DRIVE_BIT];
            ref_buffer_enable       <= wdata[REF_BUFFER_ENABLE_BIT];
            lock_one                <= 1'b1;
            if (!lock_one) begin
                detector_enable     <= wdata[DETECTOR_ENABLE_BIT];
                detect_reset_enable <= wdata[DETECT_RESET_ENABLE_BIT];
            end
        end
    end

    // set beats acknowledge; both cannot be true together anyway
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            warning_flag <= CONTROL_ONE_RESET[WARNING_FLAG_BIT];
        end else if (ce) begin
            if (warning_set) begin
                warning_flag <= 1'b1;
            end else if (ack_clear) begin
                warning_flag <= 1'b0;
            end
        end
    end

    // ==========================================================
    // control two
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            detect_trip_select  <= CONTROL_TWO_RESET[DETECT_TRIP_SELECT_BIT];
            warning_trip_select <= CONTROL_TWO_RESET[WARNING_TRIP_SELECT_MSB:WARNING_TRIP_SELECT_LSB];
            lock_two            <= 1'b0;
        end else if (ce && write_two) begin
            warning_trip_select <= wdata[WARNING_TRIP_SELECT_MSB:WARNING_TRIP_SELECT_LSB];
            lock_two            <= 1'b1;
            if (!lock_two) begin
                detect_trip_select <= wdata[DETECT_TRIP_SELECT_BIT];
            end
        end
    end

    // ==========================================================
    // event status and mask
    // a new event in the clearing cycle stays set
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            event_status <= EVENT_STATUS_RESET;
            event_mask   <= EVENT_MASK_RESET;
            detect_seen  <= 1'b0;
        end else if (ce) begin
            event_status <= (event_status & ~stat_clear) | event_set;
            detect_seen  <= detect_event;
            if (write_mask) begin
                event_mask <= wdata[1:0];
            end
        end
    end

    // ==========================================================
    // outputs
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            analog_ctrl       <= '0;
            mcu_reset_request <= 1'b0;
            irq               <= 1'b0;
        end else if (ce) begin
            analog_ctrl       <= next_analog_ctrl;
            mcu_reset_request <= next_reset_request;
            irq               <= next_irq;
        end
    end

    // ==========================================================
    // assertions
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!arst_n);

    reset_force_a: assert property (
        (ce && detect_event && detect_reset_enable) |=> mcu_reset_request)
        else $error("detect event with reset enable did not force reset");

    reset_gated_a: assert property (
        (ce && (!detector_enable || !detect_reset_enable)) |=> !mcu_reset_request)
        else $error("reset request without both enables");

    stop_gating_a: assert property (
        (ce && stop_mode && !detect_stop_enable) |=> !analog_ctrl.detector_run)
        else $error("detector running in stop mode without stop enable");

    enable_gating_a: assert property (
        (ce && !detector_enable) |=> (!analog_ctrl.detector_run && !mcu_reset_request))
        else $error("detector logic active while disabled");

    enable_lock_a: assert property (
        (ce && write_one && lock_one) |=> (detector_enable == $past(detector_enable)))
        else $error("detector enable changed after first write");

    drive_select_a: assert property (
        ce |=> (analog_ctrl.ref_buffer_high_drive == ($past(ref_buffer_enable) && $past(ref_buffer_drive_select))))
        else $error("buffer drive does not follow enable and select");

    trip_lock_a: assert property (
        (ce && write_two && lock_two) |=> $stable(detect_trip_select))
        else $error("detect trip select changed after first write");

    reserved_zero_a: assert property (
        (ce && rd_pend && rd_index == CONTROL_TWO_INDEX) |=> (hrdata[7] == 1'b0 && hrdata[3:0] == 4'h0 && hreadyout))
        else $error("reserved bits of control two read nonzero");

    region_decode_a: assert property (
        (ce && rd_take && (addr_index < REGION_FIRST_INDEX)) ##1 ce |=> (hrdata == 32'h0000_0000))
        else $error("read outside the register region returned data");

    ack_clear_a: assert property (
        (ce && ack_write && warning_present && warning_flag) |=> warning_flag)
        else $error("acknowledge cleared flag while warning present");

    warning_irq_a: assert property (
        (ce && warning_flag && warning_irq_enable) |=> irq)
        else $error("warning flag with enable did not raise interrupt");

    read_wait_a: assert property (
        (ce && rd_take) ##1 ce |-> (!hreadyout ##1 hreadyout))
        else $error("read did not answer after one wait state");

    write_ready_a: assert property (
        (ce && wr_take) |=> (hreadyout && hresp == HRESP_OKAY))
        else $error("write data phase was stretched or not okay");

    ack_reads_zero_a: assert property (
        (ce && rd_pend && rd_index == CONTROL_ONE_INDEX) |=> (hrdata[31:8] == 24'h0 && !hrdata[6]))
        else $error("acknowledge bit or upper bits of control one read nonzero");

    buffer_enable_a: assert property (
        ce |=> (analog_ctrl.ref_buffer_enable == $past(ref_buffer_enable)))
        else $error("buffer enable output does not follow its bit");

    trip_follow_a: assert property (
        ce |=> (analog_ctrl.detect_trip_select == $past(detect_trip_select)))
        else $error("detect trip output does not follow its bit");

    warn_select_a: assert property (
        ce |=> (analog_ctrl.warning_trip_select == $past(warning_trip_select)))
        else $error("warning trip output does not follow its field");

    reset_lock_a: assert property (
        (ce && write_one && lock_one) |=> $stable(detect_reset_enable))
        else $error("reset enable changed after first write");

    ack_release_a: assert property (
        (ce && ack_clear) |=> !warning_flag)
        else $error("acknowledge with warning gone did not clear flag");

    flag_sticky_a: assert property (
        (ce && warning_flag && !ack_clear) |=> warning_flag)
        else $error("warning flag dropped without acknowledge");

    irq_quiet_a: assert property (
        (ce && !(warning_flag && warning_irq_enable) && !(|(event_status & event_mask))) |=> !irq)
        else $error("interrupt raised with no enabled source");

    warn_qualify_a: assert property (
        (ce && !detector_active && !warning_flag) |=> !warning_flag)
        else $error("warning flag set while detector inactive");

    detect_qualify_a: assert property (
        (ce && !trip_sync.detect_low) |=> !mcu_reset_request)
        else $error("reset request without synchronised detect level");

endmodule : power_monitor_regs
`default_nettype wire

// ==== verification/supply_model.sv ====
// behavioural supply rail and trip comparators feeding the monitor block
`timescale 1ns/1ps
`default_nettype none
module supply_model
    import power_monitor_pkg::*;
#(
    parameter logic [15:0] DETECT_LOW_MV   = 16'h07D0,
    parameter logic [15:0] DETECT_HIGH_MV  = 16'h0A28,
    parameter logic [15:0] WARNING_BASE_MV = 16'h0AF0,
    parameter logic [15:0] WARNING_STEP_MV = 16'h0064
)
(
    // supply level and analog settings
    input  wire logic [15:0]  supply_mv,
    input  wire analog_ctrl_t analog_ctrl,
    // comparator outputs
    output var  trip_levels_t trip_levels
);
    // ==========================================================
    // trip points
    logic [15:0] detect_mv;
    logic [15:0] warning_mv;
    assign detect_mv  = analog_ctrl.detect_trip_select ? DETECT_HIGH_MV : DETECT_LOW_MV;
    assign warning_mv = WARNING_BASE_MV + 16'(analog_ctrl.warning_trip_select) * WARNING_STEP_MV;
    // ==========================================================
    // comparators left powered on purpose: the block itself must mask them when disabled
    assign trip_levels.detect_low  = (supply_mv < detect_mv);
    assign trip_levels.warning_low = (supply_mv < warning_mv);
endmodule : supply_model
`default_nettype wire

// ==== verification/testbench.sv ====
// self-checking testbench for the supply-voltage monitor register bank
`timescale 1ns/1ps
`default_nettype none
module testbench
    import power_monitor_pkg::*;
;
    // ==========================================================
    // stimulus, observation and design
    logic         clock     = 1'b0;
    logic         arst_n    = 1'b0;
    logic         hsel      = 1'b0;
    logic [31:0]  haddr     = 32'h0;
    logic [1:0]   htrans    = 2'h0;
    logic         hwrite    = 1'b0;
    logic [31:0]  hwdata    = 32'h0;
    logic         stop_mode = 1'b0;
    logic [15:0]  supply_mv = 16'h0CE4;
    logic         hreadyout;
    logic         hresp;
    logic [31:0]  hrdata;
    logic         mcu_reset_request;
    logic         irq;
    analog_ctrl_t analog_ctrl;
    trip_levels_t trip_levels;
    int           n_mismatch = 0;
    int           num_checks = 0;
    logic [7:0]   code;

    always #10 clock = ~clock;

    supply_model model_u (.supply_mv(supply_mv), .analog_ctrl(analog_ctrl), .trip_levels(trip_levels));

    power_monitor_regs dut_u (
        .clock(clock), .arst_n(arst_n), .ce(1'b1), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .trip_levels(trip_levels), .stop_mode(stop_mode),
        .analog_ctrl(analog_ctrl), .mcu_reset_request(mcu_reset_request), .irq(irq));

    // ==========================================================
    // comparison, bus and closing tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask : check

    // address phase held until hready, then data phase held until hready again
    task automatic bus(input logic wr, input logic [15:0] idx, input logic [31:0] wd, output logic [31:0] rd);
        int k;
        hsel   <= 1'b1;
        haddr  <= {14'h0000, idx, 2'h0};
        htrans <= HTRANS_NONSEQ;
        hwrite <= wr;
        k = 0;
        do begin @(posedge clock); k++; end while (hreadyout !== 1'b1 && k < 50);
        if (k >= 50) begin
            n_mismatch++;
        end
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        k = 0;
        do begin @(posedge clock); k++; end while (hreadyout !== 1'b1 && k < 50);
        rd = hrdata;
        if (k >= 50) begin
            n_mismatch++;
        end
    endtask : bus

    task automatic wr_reg(input logic [15:0] idx, input logic [7:0] wd);
        logic [31:0] rv;
        bus(1'b1, idx, {24'h000000, wd}, rv);
    endtask : wr_reg

    task automatic chk_reg(input logic [15:0] idx, input logic [7:0] exp);
        logic [31:0] rv;
        bus(1'b0, idx, 32'h0, rv);
        check(rv, {24'h000000, exp});
        check({31'h0, hresp}, {31'h0, HRESP_OKAY});
    endtask : chk_reg

    // comparator path is three edges from pin to the reset request and four to irq via the warning flag; four gives margin to the reset request
    task automatic settle();
        repeat (4) @(posedge clock);
    endtask : settle

    task automatic do_reset();
        arst_n <= 1'b0;
        repeat (6) @(posedge clock);
        arst_n <= 1'b1;
        // outputs load at the first edge and are settled only by the second
        repeat (2) @(posedge clock);
    endtask : do_reset

    task automatic print_verdict();
        $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : print_verdict

    // ==========================================================
    // watchdog
    initial begin
        repeat (4000) @(posedge clock);
        n_mismatch++;
        print_verdict();
    end

    // ==========================================================
    // main sequence
    initial begin
        do_reset();
        check({26'h0, analog_ctrl}, 32'h20);
        chk_reg(CONTROL_ONE_INDEX, 8'h1C);
        chk_reg(CONTROL_TWO_INDEX, 8'h00);
        chk_reg(EVENT_STATUS_INDEX, 8'h00);
        chk_reg(16'h3044, 8'h00);
        wr_reg(16'h2FFF, 8'hFF);
        chk_reg(16'h2FFF, 8'h00);
        wr_reg(CONTROL_ONE_INDEX, 8'h3D);
        chk_reg(CONTROL_ONE_INDEX, 8'h3D);
        check({26'h0, analog_ctrl}, 32'h22);
        // second write tries to clear the locked enables
        wr_reg(CONTROL_ONE_INDEX, 8'h2B);
        chk_reg(CONTROL_ONE_INDEX, 8'h3F);
        check({26'h0, analog_ctrl}, 32'h23);
        wr_reg(CONTROL_TWO_INDEX, 8'hFF);
        chk_reg(CONTROL_TWO_INDEX, 8'h70);
        for (int c = 0; c < 4; c++) begin
            code = 8'(c) << 4;
            wr_reg(CONTROL_TWO_INDEX, code);
            chk_reg(CONTROL_TWO_INDEX, code | 8'h40);
            check({30'h0, analog_ctrl.warning_trip_select}, 32'(c));
        end
        // warning: flag stays while the condition stands, acknowledge only after it goes
        supply_mv <= 16'h0BB8;
        settle();
        chk_reg(CONTROL_ONE_INDEX, 8'hBF);
        check({31'h0, irq}, 32'h1);
        wr_reg(CONTROL_ONE_INDEX, 8'h5F);
        chk_reg(CONTROL_ONE_INDEX, 8'h9F);
        check({31'h0, irq}, 32'h0);
        supply_mv <= 16'h0CE4;
        wr_reg(CONTROL_ONE_INDEX, 8'h3F);
        settle();
        chk_reg(CONTROL_ONE_INDEX, 8'hBF);
        wr_reg(CONTROL_ONE_INDEX, 8'h7F);
        chk_reg(CONTROL_ONE_INDEX, 8'h3F);
        check({31'h0, irq}, 32'h0);
        // sticky event status, mask and write-one-to-clear
        chk_reg(EVENT_STATUS_INDEX, 8'h01);
        wr_reg(EVENT_MASK_INDEX, 8'h01);
        chk_reg(EVENT_MASK_INDEX, 8'h01);
        check({31'h0, irq}, 32'h1);
        wr_reg(EVENT_MASK_INDEX, 8'h00);
        chk_reg(EVENT_MASK_INDEX, 8'h00);
        check({31'h0, irq}, 32'h0);
        wr_reg(EVENT_MASK_INDEX, 8'h01);
        wr_reg(EVENT_STATUS_INDEX, 8'h01);
        chk_reg(EVENT_STATUS_INDEX, 8'h00);
        check({31'h0, irq}, 32'h0);
        // detect with reset enabled, then stop mode with and without stop enable
        supply_mv <= 16'h09C4;
        settle();
        check({31'h0, mcu_reset_request}, 32'h1);
        stop_mode <= 1'b1;
        settle();
        check({31'h0, mcu_reset_request}, 32'h1);
        wr_reg(CONTROL_ONE_INDEX, 8'h37);
        settle();
        check({31'h0, mcu_reset_request}, 32'h0);
        stop_mode <= 1'b0;
        settle();
        check({31'h0, mcu_reset_request}, 32'h1);
        chk_reg(EVENT_STATUS_INDEX, 8'h03);
        supply_mv <= 16'h0CE4;
        settle();
        check({31'h0, mcu_reset_request}, 32'h0);
        // second reset: detector left disabled, reset enable alone has no effect
        do_reset();
        wr_reg(CONTROL_TWO_INDEX, 8'h20);
        chk_reg(CONTROL_TWO_INDEX, 8'h20);
        wr_reg(CONTROL_ONE_INDEX, 8'h10);
        supply_mv <= 16'h0700;
        settle();
        check({31'h0, mcu_reset_request}, 32'h0);
        check({26'h0, analog_ctrl}, 32'h08);
        wr_reg(CONTROL_ONE_INDEX, 8'h14);
        chk_reg(CONTROL_ONE_INDEX, 8'h10);
        print_verdict();
    end
endmodule : testbench
`default_nettype wire
